// ==== rtl/bdr_unit.sv ====
// Breakpoint debug register unit: address, status and control registers
//
// Operation
// - Four breakpoint registers each hold a 32-bit linear base address.
// - Matching compares linear addresses, before any physical translation.
// - Extended mode set: slots four and five raise invalid opcode.
// - Extended mode clear: slots four and five alias status and control.
// - Status changes only when a debug exception is raised or software writes it.
// - Hit bits 0-3 record matches regardless of enables.
// - Guard set: move sets status bit 13 and raises debug exception on the same edge.
// - Entering the handler clears the access guard.
// - Single-step sets status bit 14; others may join it.
// - Single-step has no priority; all debug sources share one exception strobe.
// - Task trap sets status bit 15; no control bit gates it.
// - Hardware may clear bits 0-3 only, never others.
// - Local enables 0,2,4,6 permit exceptions; cleared on task switch.
// - Global enables 1,3,5,7 permit exceptions; kept across task switches.
// - Extended mode types: exec, write, I/O, data read/write.
// - Legacy types: code 10 undefined, others the same.
// - Sizes: 00 one, 01 two, 11 four bytes, 10 undefined.
// - Moves allowed only in real mode, SMM or level 0.
// - Data match when any access byte falls within masked range.
`timescale 1ns/1ps
`default_nettype none
module bdr_unit (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Mode inputs
  input wire logic ext_brk_mode_bit_in,
  input wire logic real_mode_in,
  input wire logic smm_in,
  input wire logic [1:0] priv_level_in,
  // Access and events from the core
  input wire bdr_pkg::bdr_access_s access_in,
  input wire bdr_pkg::bdr_move_s move_in,
  input wire bdr_pkg::bdr_event_s event_in,
  // Answers
  output bdr_pkg::bdr_resp_s resp_out,
  output logic debug_exception_out,
  output logic [3:0] match_out,
  output logic [31:0] status_out,
  output logic [31:0] control_out
);

  // ********************
  // Registers and decode
  // ********************
  logic [31:0] debug_status;
  logic [31:0] debug_control;
  logic [4*32-1:0] brk_base;
  logic [3:0] cond_hit;
  logic [3:0] enabled_hit;
  logic [3:0] local_enable_bits;
  logic [3:0] global_enable_bits;
  logic move_priv_ok;
  logic move_undef;
  logic move_guarded;
  logic move_ok;
  logic [2:0] eff_idx;
  logic addr_wr;
  logic exc_now;
  bdr_pkg::bdr_state_e state;
  bdr_pkg::bdr_state_e next_state;
  logic [31:0] next_rdata;

  assign move_priv_ok = real_mode_in || smm_in || (priv_level_in == 2'h0);
  assign move_undef = ext_brk_mode_bit_in &&
                      (move_in.index == bdr_pkg::IDX_ALIAS_STAT ||
                       move_in.index == bdr_pkg::IDX_ALIAS_CTRL);
  // guard stops the move before it executes
  assign move_guarded = move_in.valid && move_priv_ok && !move_undef &&
                        debug_control[bdr_pkg::CTRL_GUARD];
  assign move_ok = move_in.valid && move_priv_ok && !move_undef && !move_guarded;

  // alias slots onto status and control
  always_comb begin
    eff_idx = move_in.index;
    if (move_in.index == bdr_pkg::IDX_ALIAS_STAT) begin
      eff_idx = bdr_pkg::IDX_STATUS;
    end else if (move_in.index == bdr_pkg::IDX_ALIAS_CTRL) begin
      eff_idx = bdr_pkg::IDX_CONTROL;
    end
  end

  assign addr_wr = move_ok && move_in.write && (eff_idx <= bdr_pkg::IDX_BRK3);

  bdr_addr_file u_addr (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(addr_wr),
    .wr_idx_in(eff_idx[1:0]),
    .wr_data_in(move_in.wdata),
    .rd_idx_in(eff_idx[1:0]),
    .rd_data_out(),
    .entries_out(brk_base)
  );

  // ********************
  // Breakpoint comparators
  // ********************
  genvar g;
  generate
    for (g = 0; g < bdr_pkg::NUM_BRK; g++) begin : g_cmp
      logic [1:0] bp_type;
      logic [1:0] bp_size;
      logic [31:0] lo_mask;
      logic [31:0] acc_last;
      logic [31:0] bp_lo;
      logic [31:0] bp_hi;
      logic [31:0] acc_addr;
      logic kind_ok;
      assign bp_type = debug_control[bdr_pkg::CTRL_TYPE_BASE + g*bdr_pkg::CTRL_FIELD_STRIDE +: 2];
      assign bp_size = debug_control[bdr_pkg::CTRL_TYPE_BASE + g*bdr_pkg::CTRL_FIELD_STRIDE
                                     + 2 +: 2];
      // size decode; undefined code treated as one byte
      assign lo_mask = (bp_size == bdr_pkg::SIZE_FOUR) ? 32'hFFFF_FFFC :
                       (bp_size == bdr_pkg::SIZE_TWO) ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
      // base masked by size, range overlap on any byte
      assign bp_lo = brk_base[g*32 +: 32] & lo_mask;
      assign bp_hi = bp_lo | ~lo_mask;
      // linear address, I/O ports zero extended from 16 bits
      assign acc_addr = (access_in.kind == bdr_pkg::BDR_ACC_IO) ?
                        {16'h0000, access_in.addr[15:0]} : access_in.addr;
      assign acc_last = acc_addr + ((access_in.size == bdr_pkg::SIZE_FOUR) ? 32'h0000_0003 :
                        (access_in.size == bdr_pkg::SIZE_TWO) ? 32'h0000_0001 : 32'h0000_0000);
      // type decode; I/O only in extended mode
      always_comb begin
        case (bp_type)
          bdr_pkg::TYPE_EXEC: kind_ok = access_in.kind == bdr_pkg::BDR_ACC_FETCH;
          bdr_pkg::TYPE_WRITE: kind_ok = access_in.kind == bdr_pkg::BDR_ACC_WRITE;
          bdr_pkg::TYPE_IO: kind_ok = ext_brk_mode_bit_in &&
                                      access_in.kind == bdr_pkg::BDR_ACC_IO;
          bdr_pkg::TYPE_RDWR: kind_ok = access_in.kind == bdr_pkg::BDR_ACC_READ ||
                                        access_in.kind == bdr_pkg::BDR_ACC_WRITE;
          default: kind_ok = 1'b0;
        endcase
      end
      // fetch matches start address exactly with size one
      assign cond_hit[g] = access_in.valid && kind_ok &&
                           ((access_in.kind == bdr_pkg::BDR_ACC_FETCH) ?
                            (acc_addr == brk_base[g*32 +: 32]) :
                            (acc_addr <= bp_hi && acc_last >= bp_lo));
      assign local_enable_bits[g] = debug_control[2*g];
      assign global_enable_bits[g] = debug_control[2*g + 1];
      assign enabled_hit[g] = cond_hit[g] && (local_enable_bits[g] || global_enable_bits[g]);
    end
  endgenerate

  // single step and the other sources share one exception strobe
  assign exc_now = event_in.raise || event_in.single_step || move_guarded ||
                   (event_in.task_switch && event_in.task_trap) || (|enabled_hit);

  // ********************
  // Status register
  // ********************
  // only exceptions or software writes change status
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_status <= bdr_pkg::STATUS_RESET;
    end else if (exc_now) begin
      // hit bits reflect conditions, enables ignored
      debug_status[3:0] <= cond_hit;
      if (move_guarded) begin
        debug_status[bdr_pkg::STAT_REG_HIT] <= 1'b1;
      end
      if (event_in.single_step) begin
        debug_status[bdr_pkg::STAT_STEP_HIT] <= 1'b1;
      end
      if (event_in.task_switch && event_in.task_trap) begin
        debug_status[bdr_pkg::STAT_TASK_HIT] <= 1'b1;
      end
    end else if (move_ok && move_in.write && eff_idx == bdr_pkg::IDX_STATUS) begin
      // handler clears status by writing it
      debug_status <= move_in.wdata;
    end
  end

  // ********************
  // Control register
  // ********************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_control <= bdr_pkg::CONTROL_RESET;
    end else begin
      if (move_ok && move_in.write && eff_idx == bdr_pkg::IDX_CONTROL) begin
        debug_control <= move_in.wdata;
      end
      if (event_in.task_switch) begin
        debug_control <= (move_ok && move_in.write && eff_idx == bdr_pkg::IDX_CONTROL ?
                          move_in.wdata : debug_control) & ~bdr_pkg::CONTROL_LOCAL_MASK;
      end
      if (event_in.handler_entry) begin
        debug_control[bdr_pkg::CTRL_GUARD] <= 1'b0;
      end
    end
  end

  // ********************
  // Move response
  // ********************
  always_comb begin
    next_state = bdr_pkg::BDR_IDLE;
    case (state)
      bdr_pkg::BDR_IDLE: next_state = move_in.valid ? bdr_pkg::BDR_RESP : bdr_pkg::BDR_IDLE;
      bdr_pkg::BDR_RESP: next_state = move_in.valid ? bdr_pkg::BDR_RESP : bdr_pkg::BDR_IDLE;
      default: next_state = bdr_pkg::BDR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= bdr_pkg::BDR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (eff_idx == bdr_pkg::IDX_STATUS) begin
      next_rdata = debug_status;
    end else if (eff_idx == bdr_pkg::IDX_CONTROL) begin
      next_rdata = debug_control;
    end else if (eff_idx <= bdr_pkg::IDX_BRK3) begin
      // flat copy keeps the answer one cycle after the move, like status and control
      next_rdata = brk_base[eff_idx[1:0]*32 +: 32];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      resp_out <= '0;
    end else begin
      resp_out.done <= move_in.valid;
      resp_out.invalid_opcode_exception <= move_in.valid && move_undef;
      resp_out.protection_fault <= move_in.valid && !move_priv_ok;
      resp_out.guard_trap <= move_guarded;
      resp_out.rdata <= (move_ok && !move_in.write) ? next_rdata : 32'h0000_0000;
    end
  end

  // ********************
  // Status outputs
  // ********************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_exception_out <= 1'b0;
      match_out <= 4'h0;
      status_out <= bdr_pkg::STATUS_RESET;
      control_out <= bdr_pkg::CONTROL_RESET;
    end else begin
      debug_exception_out <= exc_now;
      match_out <= cond_hit;
      status_out <= debug_status;
      control_out <= debug_control;
    end
  end

  // ********************
  // Checks
  // ********************
  // status holds without cause
  a_status_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!$past(exc_now) && !($past(move_ok) && $past(move_in.write)))
    |-> $stable(debug_status)) else $error("status changed without cause");

  a_guard_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    move_guarded |=> debug_status[13] && debug_exception_out)
    else $error("guarded move missed flag");

  a_guard_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    event_in.handler_entry |=> !debug_control[13]) else $error("guard not cleared");

  a_step_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    event_in.single_step |=> debug_status[14]) else $error("step flag missing");

  a_step_raise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    event_in.single_step |=> debug_exception_out) else $error("step raised nothing");

  a_task_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (event_in.task_switch && event_in.task_trap) |=> debug_status[15])
    else $error("task flag missing");

  a_sticky_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(move_ok && move_in.write && eff_idx == bdr_pkg::IDX_STATUS)
    |=> (debug_status[31:4] & $past(debug_status[31:4])) == $past(debug_status[31:4]))
    else $error("status bit cleared by hardware");

  a_local_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    event_in.task_switch |=> (debug_control & 32'h0000_0055) == 32'h0000_0000)
    else $error("local enables kept");

  a_global_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (event_in.task_switch && !(move_ok && move_in.write && eff_idx == bdr_pkg::IDX_CONTROL))
    |=> (debug_control[7:0] & 8'hAA) == ($past(debug_control[7:0]) & 8'hAA))
    else $error("global enables lost");

  a_undef_slot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (move_in.valid && ext_brk_mode_bit_in && (move_in.index == bdr_pkg::IDX_ALIAS_STAT ||
     move_in.index == bdr_pkg::IDX_ALIAS_CTRL))
    |=> resp_out.invalid_opcode_exception) else $error("no invalid opcode");

  a_alias_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (move_ok && move_in.write && move_in.index == bdr_pkg::IDX_ALIAS_CTRL &&
     !event_in.task_switch && !event_in.handler_entry)
    |=> debug_control == $past(move_in.wdata)) else $error("alias write lost");

  a_addr_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    addr_wr |=> brk_base[$past(eff_idx[1:0])*32 +: 32] == $past(move_in.wdata))
    else $error("address write lost");

  a_priv_fault: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (move_in.valid && !real_mode_in && !smm_in && priv_level_in != 2'h0 &&
     !event_in.task_switch && !event_in.handler_entry)
    |=> resp_out.protection_fault && $stable(debug_control))
    else $error("no protection fault");

  a_move_answer: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    move_in.valid |=> resp_out.done && state == bdr_pkg::BDR_RESP)
    else $error("move not answered");

  a_hit_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    exc_now |=> debug_status[3:0] == $past(cond_hit)) else $error("hit bits wrong");

endmodule
`default_nettype wire

// ==== rtl/bdr_pkg.sv ====
// Package for the breakpoint debug register unit
package bdr_pkg;

  // ********************
  // Register indices
  // ********************
  localparam logic [2:0] IDX_BRK0 = 3'h0;
  localparam logic [2:0] IDX_BRK3 = 3'h3;
  localparam logic [2:0] IDX_ALIAS_STAT = 3'h4;
  localparam logic [2:0] IDX_ALIAS_CTRL = 3'h5;
  localparam logic [2:0] IDX_STATUS = 3'h6;
  localparam logic [2:0] IDX_CONTROL = 3'h7;

  // ********************
  // Field positions
  // ********************
  localparam int STAT_REG_HIT = 13;
  localparam int STAT_STEP_HIT = 14;
  localparam int STAT_TASK_HIT = 15;
  localparam int CTRL_EXACT_LOCAL = 8;
  localparam int CTRL_EXACT_GLOBAL = 9;
  localparam int CTRL_GUARD = 13;
  localparam int CTRL_TYPE_BASE = 16;
  localparam int CTRL_FIELD_STRIDE = 4;
  localparam int NUM_BRK = 4;

  // ********************
  // Reset values
  // ********************
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_LOCAL_MASK = 32'h0000_0055;

  // ********************
  // Encodings
  // ********************
  localparam logic [1:0] TYPE_EXEC = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_IO = 2'h2;
  localparam logic [1:0] TYPE_RDWR = 2'h3;
  localparam logic [1:0] SIZE_ONE = 2'h0;
  localparam logic [1:0] SIZE_TWO = 2'h1;
  localparam logic [1:0] SIZE_FOUR = 2'h3;

  // Access kinds presented by the core
  typedef enum logic [1:0] {
    BDR_ACC_FETCH = 2'h0,
    BDR_ACC_READ = 2'h1,
    BDR_ACC_WRITE = 2'h2,
    BDR_ACC_IO = 2'h3
  } bdr_acc_e;

  // One linear access from the pipeline
  typedef struct packed {
    logic valid;
    bdr_acc_e kind;
    logic [31:0] addr;
    logic [1:0] size;
  } bdr_access_s;

  // One debug register move
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] index;
    logic [31:0] wdata;
  } bdr_move_s;

  // Response to a move
  typedef struct packed {
    logic done;
    logic invalid_opcode_exception;
    logic protection_fault;
    logic guard_trap;
    logic [31:0] rdata;
  } bdr_resp_s;

  // Exception events reported by the core
  typedef struct packed {
    logic raise;
    logic single_step;
    logic task_switch;
    logic task_trap;
    logic handler_entry;
  } bdr_event_s;

  typedef enum logic [1:0] {
    BDR_IDLE = 2'b00,
    BDR_RESP = 2'b01
  } bdr_state_e;

endpackage

// ==== rtl/bdr_addr_file.sv ====
// Four breakpoint linear address registers with registered read port
`timescale 1ns/1ps
`default_nettype none
module bdr_addr_file (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [1:0] wr_idx_in,
  input wire logic [31:0] wr_data_in,
  // Read port
  input wire logic [1:0] rd_idx_in,
  output logic [31:0] rd_data_out,
  // All entries for the comparators
  output logic [4*32-1:0] entries_out
);

  logic [31:0] mem [0:3];

  // ********************
  // Storage
  // ********************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ent
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          mem[g] <= bdr_pkg::ADDR_RESET;
        end else if (wr_en_in && wr_idx_in == 2'(g)) begin
          mem[g] <= wr_data_in;
        end
      end
      assign entries_out[g*32 +: 32] = mem[g];
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= bdr_pkg::ADDR_RESET;
    end else begin
      rd_data_out <= mem[rd_idx_in];
    end
  end

endmodule
`default_nettype wire

// ==== verification/bdr_core_model.sv ====
// Core-side model that issues accesses, register moves and events
`timescale 1ns/1ps
`default_nettype none
module bdr_core_model (
  // Clock
  input wire logic clk_in,
  // Answers from the unit
  input wire bdr_pkg::bdr_resp_s resp_in,
  input wire logic debug_exception_in,
  input wire logic [3:0] match_in,
  // Requests to the unit
  output var bdr_pkg::bdr_access_s access_out,
  output var bdr_pkg::bdr_move_s move_out,
  output var bdr_pkg::bdr_event_s event_out
);
  initial begin
    access_out = '0;
    move_out = '0;
    event_out = '0;
  end

  // ********************
  // Requests, one cycle each, answer read after the taking edge
  // ********************
  task automatic move(input logic wr, input logic [2:0] idx, input logic [31:0] wd,
                      output bdr_pkg::bdr_resp_s r, output logic dx);
    @(posedge clk_in);
    move_out <= {1'b1, wr, idx, wd};
    @(posedge clk_in);
    move_out.valid <= 1'b0;
    #1;
    r = resp_in;
    dx = debug_exception_in;
  endtask

  task automatic access(input logic [1:0] kind, input logic [31:0] addr, input logic [1:0] sz,
                        output logic [3:0] m, output logic dx);
    logic [1:0] sz_used;
    sz_used = (kind == 2'h0) ? 2'h0 : sz;
    @(posedge clk_in);
    access_out <= {1'b1, kind, addr, sz_used};
    @(posedge clk_in);
    access_out.valid <= 1'b0;
    #1;
    m = match_in;
    dx = debug_exception_in;
  endtask

  task automatic event_pulse(input bdr_pkg::bdr_event_s ev, output logic dx);
    @(posedge clk_in);
    event_out <= ev;
    @(posedge clk_in);
    event_out <= '0;
    #1;
    dx = debug_exception_in;
  endtask

  task automatic clear_status(output bdr_pkg::bdr_resp_s r);
    logic dx;
    move(1'b1, bdr_pkg::IDX_STATUS, 32'h0000_0000, r, dx);
  endtask
endmodule
`default_nettype wire

// ==== verification/breakpoint_debug_registers_tb.sv ====
// Self-checking bench for the breakpoint debug register unit
`timescale 1ns/1ps
`default_nettype none
module breakpoint_debug_registers_tb;
  logic clk_in, rst_n_in, ext_brk_mode_bit_in, real_mode_in, smm_in, dx;
  logic [1:0] priv_level_in;
  bdr_pkg::bdr_access_s access_in;
  bdr_pkg::bdr_move_s move_in;
  bdr_pkg::bdr_event_s event_in;
  bdr_pkg::bdr_resp_s resp_out, r;
  logic debug_exception_out;
  logic [3:0] match_out, m;
  logic [31:0] status_out, control_out, exp_stat, ctrl;
  int fail_count, compares, ty;
  logic [1:0] kinds [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  // Kind, address, size, expected matches
  logic [39:0] tab [8] = '{{2'h1, 32'h000A_0001, 2'h0, 4'h1}, {2'h2, 32'h000A_0001, 2'h1, 4'h3},
    {2'h2, 32'h000A_0002, 2'h0, 4'h2}, {2'h1, 32'h000B_0001, 2'h3, 4'h4},
    {2'h2, 32'h000C_0000, 2'h3, 4'h8}, {2'h2, 32'h000C_0002, 2'h1, 4'h8},
    {2'h1, 32'h000A_0000, 2'h0, 4'h0}, {2'h1, 32'h000C_0000, 2'h1, 4'h0}};

  bdr_unit u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ext_brk_mode_bit_in(ext_brk_mode_bit_in),
    .real_mode_in(real_mode_in), .smm_in(smm_in), .priv_level_in(priv_level_in),
    .access_in(access_in), .move_in(move_in), .event_in(event_in), .resp_out(resp_out),
    .debug_exception_out(debug_exception_out), .match_out(match_out), .status_out(status_out),
    .control_out(control_out));
  bdr_core_model u_core (.clk_in(clk_in), .resp_in(resp_out), .debug_exception_in(debug_exception_out),
    .match_in(match_out), .access_out(access_in), .move_out(move_in), .event_out(event_in));

  // ********************
  // Checks and register tasks
  // ********************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    u_core.move(1'b1, idx, d, r, dx);
    chk("write done", 32'h0000_0001, 32'(r.done));
  endtask

  task automatic rd(input logic [2:0] idx, input logic [31:0] exp, input string name);
    u_core.move(1'b0, idx, 32'h0000_0000, r, dx);
    chk(name, exp, r.rdata);
  endtask

  task automatic acc(input logic [39:0] e);
    logic [3:0] en;
    logic hit;
    en = {ctrl[7] | ctrl[6], ctrl[5] | ctrl[4], ctrl[3] | ctrl[2], ctrl[1] | ctrl[0]};
    hit = |(e[3:0] & en);
    u_core.access(e[39:38], e[37:6], e[5:4], m, dx);
    chk("match", 32'(e[3:0]), 32'(m));
    chk("exception", 32'(hit), 32'(dx));
    if (hit) begin
      exp_stat[3:0] = e[3:0];
    end
    rd(bdr_pkg::IDX_STATUS, exp_stat, "status");
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  initial begin
    #200000;
    fail_count++;
    complete_run();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    {rst_n_in, ext_brk_mode_bit_in, real_mode_in, smm_in, priv_level_in} = '0;
    {fail_count, compares} = '0;
    exp_stat = 32'h0000_0000;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(bdr_pkg::IDX_STATUS, 32'h0000_0000, "status reset");
    rd(bdr_pkg::IDX_CONTROL, 32'h0000_0000, "control reset");
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      real_mode_in <= (i == 1);
      smm_in <= (i == 2);
      priv_level_in <= 2'h3;
      u_core.move(1'b1, bdr_pkg::IDX_CONTROL, (i == 0) ? 32'hFFFF_FFFF : 32'h0000_0000, r, dx);
      chk("protection fault", 32'(i == 0), 32'(r.protection_fault));
    end
    @(posedge clk_in);
    {real_mode_in, smm_in, priv_level_in} <= '0;
    rd(bdr_pkg::IDX_CONTROL, 32'h0000_0000, "control after fault");
    $display("test privilege done");
    wr(bdr_pkg::IDX_ALIAS_CTRL, 32'h0000_0300);
    rd(bdr_pkg::IDX_CONTROL, 32'h0000_0300, "control via alias");
    rd(bdr_pkg::IDX_ALIAS_STAT, 32'h0000_0000, "status via alias");
    @(posedge clk_in);
    ext_brk_mode_bit_in <= 1'b1;
    u_core.move(1'b0, bdr_pkg::IDX_ALIAS_STAT, 32'h0000_0000, r, dx);
    chk("invalid opcode read", 32'h0000_0001, 32'(r.invalid_opcode_exception));
    u_core.move(1'b1, bdr_pkg::IDX_ALIAS_CTRL, 32'hFFFF_FFFF, r, dx);
    chk("invalid opcode write", 32'h0000_0001, 32'(r.invalid_opcode_exception));
    rd(bdr_pkg::IDX_CONTROL, 32'h0000_0300, "control kept");
    $display("test alias done");
    wr(bdr_pkg::IDX_BRK0, 32'h0000_A001);
    for (int t = 0; t < 5; t++) begin
      ty = (t == 4) ? 2 : t;
      ctrl = 32'h0000_0002 | (32'(ty) << 16);
      @(posedge clk_in);
      ext_brk_mode_bit_in <= (t < 4);
      wr(bdr_pkg::IDX_CONTROL, ctrl);
      acc({kinds[ty], 32'h0000_A001, 2'h0, (t < 4) ? 4'h1 : 4'h0});
    end
    $display("test type decode done");
    wr(bdr_pkg::IDX_BRK0, 32'h000A_0001);
    wr(bdr_pkg::IDX_BRK0 + 3'h1, 32'h000A_0002);
    wr(bdr_pkg::IDX_BRK0 + 3'h2, 32'h000B_0002);
    wr(bdr_pkg::IDX_BRK3, 32'h000C_0000);
    rd(bdr_pkg::IDX_BRK0 + 3'h2, 32'h000B_0002, "address readback");
    ctrl = 32'hD713_0312;
    wr(bdr_pkg::IDX_CONTROL, ctrl);
    for (int i = 0; i < 8; i++) begin
      acc(tab[i]);
    end
    $display("test range match done");
    u_core.event_pulse(5'b00100, dx);
    chk("switch no exception", 32'h0000_0000, 32'(dx));
    rd(bdr_pkg::IDX_CONTROL, 32'hD713_0302, "control after switch");
    u_core.event_pulse(5'b00110, dx);
    chk("trap exception", 32'h0000_0001, 32'(dx));
    exp_stat = {exp_stat[31:16], 1'b1, exp_stat[14:4], 4'h0};
    rd(bdr_pkg::IDX_STATUS, exp_stat, "status task hit");
    u_core.event_pulse(5'b01000, dx);
    chk("step exception", 32'h0000_0001, 32'(dx));
    exp_stat[14] = 1'b1;
    rd(bdr_pkg::IDX_STATUS, exp_stat, "status step hit");
    u_core.event_pulse(5'b10000, dx);
    chk("raise exception", 32'h0000_0001, 32'(dx));
    rd(bdr_pkg::IDX_STATUS, exp_stat, "status after raise");
    $display("test events done");
    wr(bdr_pkg::IDX_CONTROL, 32'hD713_2302);
    u_core.move(1'b0, bdr_pkg::IDX_BRK0, 32'h0000_0000, r, dx);
    chk("guard trap", 32'h0000_0001, 32'(r.guard_trap));
    chk("guard exception", 32'h0000_0001, 32'(dx));
    exp_stat[13] = 1'b1;
    @(posedge clk_in);
    #1;
    chk("status output", exp_stat, status_out);
    chk("control output", 32'hD713_2302, control_out);
    u_core.event_pulse(5'b00001, dx);
    rd(bdr_pkg::IDX_CONTROL, 32'hD713_0302, "control after entry");
    u_core.clear_status(r);
    rd(bdr_pkg::IDX_STATUS, 32'h0000_0000, "status cleared");
    $display("test guard done");
    complete_run();
  end
endmodule
`default_nettype wire
